// file: core/pefs_pkg.sv
// package for the port e function select block: offsets, fields, mode codes
// assumes a byte-wide register port and mode code from the mode logic
package pefs_pkg;
   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [9:0] PEFS_ASSIGN_OFF = 10'h00A;
   localparam int PEFS_NOACC_BIT = 7;
   localparam int PEFS_PIPE_BIT = 5;
   localparam int PEFS_ECLK_DIS_BIT = 4;
   localparam int PEFS_LOW_BYTE_STROBE_BIT = 3;
   localparam int PEFS_RDWR_BIT = 2;
   localparam logic [7:0] PEFS_IMPL_MASK = 8'hBC;
   // ***************************************************
   // operating modes and reset values
   // ***************************************************
   typedef enum logic [2:0] {
      PEFS_SPECIAL_SINGLE,
      PEFS_SPECIAL_TEST,
      PEFS_PERIPHERAL,
      PEFS_EMUL_NARROW,
      PEFS_EMUL_WIDE,
      PEFS_NORMAL_SINGLE,
      PEFS_NORMAL_NARROW,
      PEFS_NORMAL_WIDE
   } pefs_mode_e;
   localparam logic [7:0] PEFS_RST_ZERO = 8'h00;
   localparam logic [7:0] PEFS_RST_TEST = 8'h2C;
   localparam logic [7:0] PEFS_RST_EMUL = 8'hAC;
   localparam logic [7:0] PEFS_RST_NSINGLE = 8'h10;
   localparam logic [7:0] PEFS_RESET_Q = 8'h00;
endpackage

// file: core/pefs_pin_mux.sv
// per-pin select between general-purpose i/o and a bus control signal
// assumes control values and enables arrive from the bus controller
`timescale 1ns/1ps
module pefs_pin_mux
   import pefs_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic [WIDTH-1:0] alt_sel,
   input wire logic [WIDTH-1:0] alt_out,
   input wire logic [WIDTH-1:0] alt_oe,
   input wire logic [WIDTH-1:0] gpio_out,
   input wire logic [WIDTH-1:0] port_e_direction_bits,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe
);
   // a zero-wide mux has nothing to select
   if (WIDTH < 1)
   begin : g_bad_width
      $error("width must be positive");
   end
   // RQ5: direction overridden
   assign pin_out = (alt_sel & alt_out) | (~alt_sel & gpio_out);
   assign pin_oe = (alt_sel & alt_oe) | (~alt_sel & port_e_direction_bits);
endmodule

// file: core/pefs_top.sv
// port e function assignment register and port e pin multiplexer
// assumes mode code is stable from reset release; pins synchronous to mclk
// limitation: every implemented bit is writable in each mapped mode
// Behaviour
// RQ1: reset value chosen by operating mode
// RQ2: normal single chip: all pins gpio
// RQ3: normal expanded: only e clock enabled
// RQ4: test and emulation: control signals after reset
// RQ5: selected function overrides direction bit
// RQ6: register readable whenever in the map
// RQ7: absent from map in expanded, peripheral
// RQ8: register at offset 0x000A of block
// RQ9: software enables extra signals before use
// RQ10: bit layout; bits 6,1,0 read zero
// RQ11: unimplemented writes ignored; permitted updates only
`timescale 1ns/1ps
module pefs_top
   import pefs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [2:0] op_mode,
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_external,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_oe,
   input wire logic [7:0] gpio_out,
   input wire logic [7:0] port_e_direction_bits,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic no_access_cycle_out_en,
   output logic pipe_status_out_en,
   output logic bus_clock_out_en,
   output logic low_byte_strobe_en,
   output logic read_write_out_en
);
   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic [7:0] port_e_function_assign;
      logic loaded;
      logic [7:0] rdata;
   } pefs_state_s;

   pefs_state_s st_q;
   pefs_state_s st_d;
   logic [7:0] sel;
   logic in_map;
   logic hit;
   logic wr_take;
   logic rd_take;

   // RQ1: mode reset value
   function automatic logic [7:0] mode_reset(input logic [2:0] m);
      case (pefs_mode_e'(m))
         PEFS_SPECIAL_TEST: mode_reset = PEFS_RST_TEST;
         PEFS_EMUL_NARROW,
         PEFS_EMUL_WIDE: mode_reset = PEFS_RST_EMUL;
         PEFS_NORMAL_SINGLE: mode_reset = PEFS_RST_NSINGLE;
         // special single, peripheral and normal expanded start all clear
         PEFS_SPECIAL_SINGLE,
         PEFS_PERIPHERAL,
         PEFS_NORMAL_NARROW,
         PEFS_NORMAL_WIDE: mode_reset = PEFS_RST_ZERO;
         default: mode_reset = PEFS_RST_ZERO;
      endcase
   endfunction

   // RQ7: map presence
   function automatic logic mapped(input logic [2:0] m);
      case (pefs_mode_e'(m))
         PEFS_SPECIAL_SINGLE,
         PEFS_SPECIAL_TEST,
         PEFS_NORMAL_SINGLE: mapped = 1'h1;
         default: mapped = 1'h0;
      endcase
   endfunction

   // one strobe taken at the register slot while the register is mapped
   function automatic logic take(input logic strobe, input logic slot, input logic live);
      take = strobe & slot & live;
   endfunction

   // ***************************************************
   // elaboration checks
   // ***************************************************
   // a reset image with a reserved bit set would store it there, though reads mask it to zero
   if ((PEFS_RST_TEST & ~PEFS_IMPL_MASK) != 8'h00)
   begin : g_bad_rst_test
      $error("test reset image sets reserved bits");
   end
   if ((PEFS_RST_EMUL & ~PEFS_IMPL_MASK) != 8'h00)
   begin : g_bad_rst_emul
      $error("emulation reset image sets reserved bits");
   end
   if ((PEFS_RST_NSINGLE & ~PEFS_IMPL_MASK) != 8'h00)
   begin : g_bad_rst_nsingle
      $error("single chip reset image sets reserved bits");
   end
   if (PEFS_RST_ZERO != 8'h00)
   begin : g_bad_rst_zero
      $error("zero reset image is not zero");
   end
   // every enable field must sit on an implemented bit
   if (PEFS_IMPL_MASK[PEFS_NOACC_BIT] != 1'h1)
   begin : g_bad_noacc
      $error("no access field outside the mask");
   end
   if (PEFS_IMPL_MASK[PEFS_PIPE_BIT] != 1'h1)
   begin : g_bad_pipe
      $error("pipe status field outside the mask");
   end
   if (PEFS_IMPL_MASK[PEFS_ECLK_DIS_BIT] != 1'h1)
   begin : g_bad_eclk
      $error("e clock field outside the mask");
   end
   if (PEFS_IMPL_MASK[PEFS_LOW_BYTE_STROBE_BIT] != 1'h1)
   begin : g_bad_low_byte_strobe
      $error("low strobe field outside the mask");
   end
   if (PEFS_IMPL_MASK[PEFS_RDWR_BIT] != 1'h1)
   begin : g_bad_rdwr
      $error("read write field outside the mask");
   end
   // five enables and no more, so bits 6, 1 and 0 stay read-as-zero
   if ($countones(PEFS_IMPL_MASK) != 5)
   begin : g_bad_mask
      $error("implemented mask must hold five bits");
   end

   // ***************************************************
   // register access
   // ***************************************************
   assign in_map = mapped(op_mode);
   // RQ8: address decode
   assign hit = (reg_addr == PEFS_ASSIGN_OFF);
   // RQ7: echoed externally
   assign reg_external = hit & ~in_map & (reg_wr | reg_rd);
   // RQ11: only taken strobes touch storage
   assign wr_take = take(reg_wr, hit, in_map);
   assign rd_take = take(reg_rd, hit, in_map);

   always_comb
   begin
      st_d = st_q;
      // read data idles at zero so an or-combined read bus stays clean
      st_d.rdata = 8'h00;
      // strap is caught on the first clock after release, not in reset
      if (!st_q.loaded)
      begin
         // RQ1: mode dependent load
         st_d.port_e_function_assign = mode_reset(op_mode);
         st_d.loaded = 1'b1;
      end
      else if (wr_take)
      begin
         // RQ11: mask reserved bits
         st_d.port_e_function_assign = reg_wdata & PEFS_IMPL_MASK;
      end
      if (rd_take)
      begin
         // RQ6: read anytime
         st_d.rdata = st_q.port_e_function_assign & PEFS_IMPL_MASK;
      end
   end

   // reset clears only; the mode image waits one clock, as the branch takes constants
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;

   // ***************************************************
   // pin selects
   // ***************************************************
   // RQ10: field positions
   assign no_access_cycle_out_en = st_q.port_e_function_assign[PEFS_NOACC_BIT];
   assign pipe_status_out_en = st_q.port_e_function_assign[PEFS_PIPE_BIT];
   assign low_byte_strobe_en = st_q.port_e_function_assign[PEFS_LOW_BYTE_STROBE_BIT];
   assign read_write_out_en = st_q.port_e_function_assign[PEFS_RDWR_BIT];
   // RQ2: e clock off after reset in normal single chip; special single chip starts with it on
   // RQ3: e clock on by default otherwise
   assign bus_clock_out_en = st_q.loaded & ~st_q.port_e_function_assign[PEFS_ECLK_DIS_BIT];

   // pin map: 7 noacc, 6,5 pipe, 4 e clock, 3 low_byte_strobe, 2 r/w, 1,0 gpio only
   // RQ4: control pins selected
   assign sel[7] = no_access_cycle_out_en;
   // both pipe status pins follow one enable bit
   assign sel[6] = pipe_status_out_en;
   assign sel[5] = pipe_status_out_en;
   assign sel[4] = bus_clock_out_en;
   assign sel[3] = low_byte_strobe_en;
   assign sel[2] = read_write_out_en;
   // pins 1 and 0 have no control function
   assign sel[1:0] = 2'h0;

   // ***************************************************
   // pin multiplexer
   // ***************************************************
   // RQ5: direction overridden
   pefs_pin_mux #(.WIDTH(8)) u_mux (
      .alt_sel(sel),
      .alt_out(alt_out),
      .alt_oe(alt_oe),
      .gpio_out(gpio_out),
      .port_e_direction_bits(port_e_direction_bits),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );
endmodule

// file: tb/pefs_assertions.sv
// checker for the port e function select top, bound to its ports
// assumes the mode code holds steady while out of reset
`timescale 1ns/1ps
module pefs_assertions
   import pefs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_external,
   input wire logic [2:0] op_mode,
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] alt_oe,
   input wire logic [7:0] port_e_direction_bits,
   input wire logic [7:0] pin_oe,
   input wire logic no_access_cycle_out_en,
   input wire logic pipe_status_out_en,
   input wire logic bus_clock_out_en,
   input wire logic low_byte_strobe_en,
   input wire logic read_write_out_en
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   wire hit = reg_addr == PEFS_ASSIGN_OFF;
   wire in_map = op_mode inside {3'h0, 3'h1, 3'h5};
   wire [4:0] en = {no_access_cycle_out_en, pipe_status_out_en, bus_clock_out_en,
      low_byte_strobe_en, read_write_out_en};
   // a write on the first clock after reset is lost to the mode load
   sequence s_wr;
      !$past(reset) && reg_wr && hit && in_map;
   endsequence
   property p_rz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rz: assert property (p_rz) else $error("read data out of slot");
   property p_rsv; (reg_rdata & 8'h43) == 8'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_en; s_wr |=> en == $past({reg_wdata[7], reg_wdata[5], ~reg_wdata[4],
      reg_wdata[3:2]}); endproperty
   a_en: assert property (p_en) else $error("enables not loaded");
   property p_ext; (reg_wr || reg_rd) && hit |-> reg_external == !in_map; endproperty
   a_ext: assert property (p_ext) else $error("external echo wrong");
   property p_pin; pin_oe[7] == (en[4] ? alt_oe[7] : port_e_direction_bits[7])
      && pin_oe[4] == (en[2] ? alt_oe[4] : port_e_direction_bits[4]); endproperty
   a_pin: assert property (p_pin) else $error("pin enable mux wrong");
   property p_rs; $fell(reset) && op_mode == 3'h5 |=> en == 5'h00; endproperty
   a_rs: assert property (p_rs) else $error("single chip reset");
   property p_rx; $fell(reset) && op_mode[2:1] == 2'h3 |=> en == 5'h04; endproperty
   a_rx: assert property (p_rx) else $error("expanded reset");
   property p_rt; $fell(reset) && op_mode inside {3'h1, 3'h3, 3'h4} |=> en[3:0] == 4'hF;
   endproperty
   a_rt: assert property (p_rt) else $error("test or emulation reset");
endmodule
bind pefs_top pefs_assertions u_chk (
   .mclk(mclk),
   .reset(reset),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_external(reg_external),
   .op_mode(op_mode),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .alt_oe(alt_oe),
   .port_e_direction_bits(port_e_direction_bits),
   .pin_oe(pin_oe),
   .no_access_cycle_out_en(no_access_cycle_out_en),
   .pipe_status_out_en(pipe_status_out_en),
   .bus_clock_out_en(bus_clock_out_en),
   .low_byte_strobe_en(low_byte_strobe_en),
   .read_write_out_en(read_write_out_en)
);

// file: tb/pefs_bus_model.sv
// stand-in for the bus logic feeding control values to port e
// alt_out flips every cycle so a stuck mux path cannot pass; alt_oe is fixed
`timescale 1ns/1ps
module pefs_bus_model (
   input wire logic mclk,
   output logic [7:0] alt_out,
   output logic [7:0] alt_oe
);
   assign alt_oe = 8'hFC;
   initial alt_out = 8'h5A;
   always @(posedge mclk) alt_out <= ~alt_out;
endmodule

// file: tb/tb_top.sv
// register tests of the port e function select block through its byte port
// assumes the bus model drives the control side; gpio and direction are fixed patterns
`timescale 1ns/1ps
module tb_top
   import pefs_pkg::*;
;
   logic mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, reg_external, xs;
   logic [2:0] op_mode = 0, mm;
   logic [9:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata, pin_out, pin_oe, alt_out, alt_oe;
   logic [7:0] dir = 8'h21, gpio = 8'h96;
   logic [4:0] en;
   int num_errors = 0, n_tests = 0, cyc = 0;
   logic [7:0] rv [8] = '{PEFS_RST_ZERO, PEFS_RST_TEST, PEFS_RST_ZERO, PEFS_RST_EMUL,
      PEFS_RST_EMUL, PEFS_RST_NSINGLE, PEFS_RST_ZERO, PEFS_RST_ZERO};
   pefs_bus_model BUS (.mclk(mclk), .alt_out(alt_out), .alt_oe(alt_oe));
   pefs_top DUT (.mclk(mclk), .reset(reset), .op_mode(op_mode), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_external(reg_external), .alt_out(alt_out), .alt_oe(alt_oe), .gpio_out(gpio),
      .port_e_direction_bits(dir), .pin_out(pin_out), .pin_oe(pin_oe),
      .no_access_cycle_out_en(en[4]), .pipe_status_out_en(en[3]), .bus_clock_out_en(en[2]),
      .low_byte_strobe_en(en[1]), .read_write_out_en(en[0]));
   initial forever #10 mclk = ~mclk;
   always @(posedge mclk) if (++cyc == 3000)
   begin
      num_errors++;
      results();
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e)
      begin
         num_errors++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   // one strobe cycle; echo flag taken 1 ns into the strobe cycle, read data one cycle later
   task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      #1 xs = reg_external;
      @(posedge mclk);
      reg_wr <= 0;
      reg_rd <= 0;
      #1;
   endtask
   task results;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      // mode order ends in normal single chip, where the register is writable
      for (int m = 0; m < 8; m++)
      begin
         mm = 3'(m + 6);
         @(posedge mclk);
         reset <= 1;
         op_mode <= mm;
         repeat (12) @(posedge mclk);
         reset <= 0;
         @(posedge mclk);
         #1 chk({3'h0, en}, {3'h0, rv[mm][7], rv[mm][5], ~rv[mm][4], rv[mm][3:2]});
         acc(0, PEFS_ASSIGN_OFF, 8'h00);
         chk(reg_rdata, mm inside {0, 1, 5} ? rv[mm] : 8'h00);
         chk({7'h0, xs}, {7'h0, !(mm inside {0, 1, 5})});
         $display("reset test mode %0d done", mm);
      end
      acc(1, PEFS_ASSIGN_OFF, 8'hFF);
      chk({3'h0, en}, 8'h1B);
      chk(pin_oe, 8'hED);
      chk(pin_out, (alt_out & 8'hEC) | 8'h12);
      acc(0, PEFS_ASSIGN_OFF, 8'h00);
      chk(reg_rdata, 8'hBC);
      acc(1, 10'h00B, 8'h00);
      acc(0, 10'h00B, 8'h00);
      chk(reg_rdata, 8'h00);
      acc(0, PEFS_ASSIGN_OFF, 8'h00);
      chk(reg_rdata, 8'hBC);
      // write of reserved bits only clears every enable but the e clock
      acc(1, PEFS_ASSIGN_OFF, 8'h43);
      chk({3'h0, en}, 8'h04);
      chk(pin_oe, 8'h31);
      chk(pin_out, (alt_out & 8'h10) | 8'h86);
      acc(0, PEFS_ASSIGN_OFF, 8'h00);
      chk(reg_rdata, 8'h00);
      $display("register test done");
      results();
   end
endmodule
